//--- logic/lsp_host_port.sv
/*
  Bus slave host port of a UV and ambient light sensor: address decode,
  register pointer, register file, command execution, measurement
  sequencing and the open-drain interrupt.
  Assumes an analog front end that integrates while integrate_out is high
  and presents a stable result and saturation flag at the window end.
*/
// Notes on behaviour
// - Acknowledge fixed seven-bit address 0x60.
// - General call 0x00; byte 0x06 resets.
// - Seven-bit addressing only, no ten-bit.
// - Write: address, pointer, then sequential data.
// - Read: device shifts out pointed register.
// - Burst reads and writes over contiguous registers.
// - Pointer bits 5-0, bit 6 disables increment.
// - Increment disabled keeps pointer fixed.
// - Autonomous measurements interrupt after each completion.
// - Saturation flags response, result reads 0xFFFF.
// - Result recovers once light in range.
// - Overflow flag held until no-operation command.
// - Commands still execute while overflow held.
// - Infrared measurement skipped when disabled.
// - Integration default 25.6 us, up to 3.28 ms.
// - Auxiliary result holds hundred times UV index.
// - Command 0x12 at 0x18 loads calibration.
// - Calibration lands at 0x22 through 0x2D.
// - Response low nibble counts executed commands.
// - Interrupt held until host clears it.
`timescale 1ns/100ps
module lsp_host_port
  import lsp_pkg::*;
#(
  parameter int INT_BASE_CYCLES = LSP_INT_BASE_CYC,
  parameter int AUX_CYCLES = LSP_AUX_CYC,
  parameter int RATE_TICK_CYCLES = LSP_RATE_TICK_CYC
) (
  // System clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_drive_out,
  output logic sda_oe_n_out,
  // Interrupt pin
  output logic int_drive_out,
  output logic int_oe_n_out,
  // Analog front end
  input wire logic [15:0] adc_value_in,
  input wire logic adc_sat_in,
  output logic integrate_out,
  output logic [1:0] meas_chan_out,
  output logic vis_high_range_out,
  output logic ir_high_range_out,
  output logic [31:0] ucoef_out
);
  // ----------------------------------------------------------------
  // Bus side, clocked by the host's bus clock
  // ----------------------------------------------------------------
  lsp_link_t lk_q;
  logic [2:0] bit_q;
  logic [7:0] rx_q, tx_q, wr_data_q, rd_data_q;
  logic [5:0] ptr_q, wr_addr_q;
  logic ainc_dis_q, rd_q, gc_q, start_tog_q, st_seen_q;
  logic wr_tog_q, rq_tog_q, gc_tog_q, sda_oe_n_q;
  wire [7:0] byte_w = {rx_q[6:0], sda_in};
  wire byte_end = bit_q == 3'h7;
  wire [5:0] ptr_next = ainc_dis_q ? ptr_q : 6'(ptr_q + 6'h01);

  // Start marked on a falling data line while the clock is high
  always_ff @(negedge sda_in or negedge rst_n_in) begin
    if (!rst_n_in) start_tog_q <= 1'b0;
    else if (scl_in) start_tog_q <= ~start_tog_q;
  end

  // No stop detector: every transfer opens with a start, which re-arms the state
  always_ff @(posedge scl_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lk_q <= LK_IDLE; bit_q <= 3'h0; rx_q <= 8'h00; tx_q <= 8'h00;
      ptr_q <= 6'h00; ainc_dis_q <= 1'b0; rd_q <= 1'b0; gc_q <= 1'b0;
      st_seen_q <= 1'b0; wr_tog_q <= 1'b0; rq_tog_q <= 1'b0; gc_tog_q <= 1'b0;
      wr_addr_q <= 6'h00; wr_data_q <= 8'h00;
    end else if (start_tog_q != st_seen_q) begin
      st_seen_q <= start_tog_q;
      lk_q <= LK_ADDR;
      rx_q <= byte_w;
      bit_q <= 3'h1;
    end else begin
      case (lk_q)
        LK_ADDR, LK_PTR, LK_WDAT, LK_GCMD: begin
          rx_q <= byte_w;
          bit_q <= 3'(bit_q + 3'h1);
          if (byte_end && lk_q == LK_ADDR) begin
            rd_q <= byte_w[0];
            gc_q <= byte_w == LSP_GC_ADDR;
            // Only seven-bit matches answer; ten-bit headers fall through
            if (byte_w[7:1] == LSP_SLAVE_ADDR || byte_w == LSP_GC_ADDR) lk_q <= LK_AACK;
            else lk_q <= LK_IDLE;
          end else if (byte_end && lk_q == LK_PTR) begin
            ptr_q <= byte_w[5:0];
            ainc_dis_q <= byte_w[LSP_PTR_AINC_BIT];
            rq_tog_q <= ~rq_tog_q;
            lk_q <= LK_PACK;
          end else if (byte_end && lk_q == LK_WDAT) begin
            wr_addr_q <= ptr_q;
            wr_data_q <= byte_w;
            wr_tog_q <= ~wr_tog_q;
            ptr_q <= ptr_next;
            rq_tog_q <= ~rq_tog_q;
            lk_q <= LK_WACK;
          end else if (byte_end) begin
            if (byte_w == LSP_GC_RESET) gc_tog_q <= ~gc_tog_q;
            lk_q <= LK_GACK;
          end
        end
        LK_AACK, LK_RACK: begin
          bit_q <= 3'h0;
          if (lk_q == LK_RACK && sda_in) lk_q <= LK_IDLE;
          else if (lk_q == LK_AACK && gc_q) lk_q <= LK_GCMD;
          else if (lk_q == LK_AACK && !rd_q) lk_q <= LK_PTR;
          else begin
            tx_q <= rd_data_q;
            ptr_q <= ptr_next;
            rq_tog_q <= ~rq_tog_q;
            lk_q <= LK_RDAT;
          end
        end
        LK_PACK, LK_WACK: begin
          bit_q <= 3'h0;
          lk_q <= LK_WDAT;
        end
        LK_RDAT: begin
          tx_q <= {tx_q[6:0], 1'b1};
          bit_q <= 3'(bit_q + 3'h1);
          if (byte_end) lk_q <= LK_RACK;
        end
        default: lk_q <= LK_IDLE;
      endcase
    end
  end

  // Data changes only while the clock is low
  always_ff @(negedge scl_in or negedge rst_n_in) begin
    if (!rst_n_in) sda_oe_n_q <= 1'b1;
    else if (lk_q == LK_AACK || lk_q == LK_PACK || lk_q == LK_WACK || lk_q == LK_GACK) sda_oe_n_q <= 1'b0;
    else if (lk_q == LK_RDAT) sda_oe_n_q <= tx_q[7];
    else sda_oe_n_q <= 1'b1;
  end
  assign sda_oe_n_out = sda_oe_n_q;
  assign sda_drive_out = 1'b0;

  // ----------------------------------------------------------------
  // Crossing into the system clock
  // ----------------------------------------------------------------
  // Toggles cross through two flops; words they announce are held still meanwhile
  logic [2:0] sy1_q, sy2_q, sy3_q;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sy1_q <= 3'h0; sy2_q <= 3'h0; sy3_q <= 3'h0;
    end else begin
      sy1_q <= {gc_tog_q, rq_tog_q, wr_tog_q};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end
  wire wr_evt = sy2_q[0] ^ sy3_q[0];
  wire rq_evt = sy2_q[1] ^ sy3_q[1];
  wire gc_evt = sy2_q[2] ^ sy3_q[2];

  // ----------------------------------------------------------------
  // Register file and commands
  // ----------------------------------------------------------------
  function automatic logic wr_hit(logic ev, logic [5:0] a, logic [5:0] off);
    return ev && a == off;
  endfunction
  logic [7:0] chan_q, range_q, key_q, rate_q, cmd_q, resp_q, resp_d;
  logic [2:0] vis_it_q, ir_it_q;
  logic [7:0] ucoef_q [4];
  logic [7:0] res_q [LSP_RESULT_BYTES];
  logic irq_q, irq_d, int_oe_n_q, auto_q;
  wire cmd_exec = wr_hit(wr_evt, wr_addr_q, LSP_REG_COMMAND);
  wire is_nop = wr_data_q == LSP_CMD_NOP;
  wire soft_rst = gc_evt || (cmd_exec && wr_data_q == LSP_CMD_RESET);
  wire cal_load = cmd_exec && wr_data_q == LSP_CMD_GET_CAL;
  wire in_ucoef = wr_evt && wr_addr_q >= LSP_REG_UCOEF0 && wr_addr_q <= LSP_REG_UCOEF3;
  wire [1:0] uc_idx = 2'(wr_addr_q - LSP_REG_UCOEF0);
  logic capture, seq_done, ovf_set;
  lsp_meas_t m_q, m_d;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in || soft_rst) begin
      chan_q <= LSP_BYTE_RST; range_q <= LSP_BYTE_RST; key_q <= LSP_BYTE_RST;
      rate_q <= LSP_BYTE_RST; cmd_q <= LSP_BYTE_RST; auto_q <= 1'b0;
      vis_it_q <= LSP_ITIME_RST; ir_it_q <= LSP_ITIME_RST;
      for (int k = 0; k < 4; k++) ucoef_q[k] <= LSP_BYTE_RST;
    end else if (wr_evt) begin
      if (wr_hit(1'b1, wr_addr_q, LSP_REG_CHAN_LIST)) chan_q <= wr_data_q;
      else if (wr_hit(1'b1, wr_addr_q, LSP_REG_RANGE)) range_q <= wr_data_q;
      else if (wr_hit(1'b1, wr_addr_q, LSP_REG_VIS_ITIME)) vis_it_q <= wr_data_q[2:0];
      else if (wr_hit(1'b1, wr_addr_q, LSP_REG_IR_ITIME)) ir_it_q <= wr_data_q[2:0];
      else if (wr_hit(1'b1, wr_addr_q, LSP_REG_HARDWARE_UNLOCK_KEY)) key_q <= wr_data_q;
      else if (wr_hit(1'b1, wr_addr_q, LSP_REG_MEAS_RATE)) rate_q <= wr_data_q;
      else if (in_ucoef) ucoef_q[uc_idx] <= wr_data_q;
      else if (cmd_exec) begin
        cmd_q <= wr_data_q;
        if (wr_data_q == LSP_CMD_AUTO) auto_q <= 1'b1;
        else if (wr_data_q == LSP_CMD_PAUSE) auto_q <= 1'b0;
      end
    end
  end

  // Overflow sets win over a same-cycle clear; commands run regardless
  always_comb begin
    resp_d = resp_q;
    if (cmd_exec && is_nop) resp_d = 8'h00;
    else if (cmd_exec) resp_d[3:0] = 4'(resp_q[3:0] + 4'h1);
    if (ovf_set) resp_d[LSP_RESP_OVF_BIT] = 1'b1;
  end
  // Set wins over a write-one clear of the done flag
  assign irq_d = seq_done || (irq_q && !(wr_hit(wr_evt, wr_addr_q, LSP_REG_IRQ_STATUS)
                 && wr_data_q[LSP_IRQ_DONE_BIT]));
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in || soft_rst) begin
      resp_q <= 8'h00; irq_q <= 1'b0; int_oe_n_q <= 1'b1;
    end else begin
      resp_q <= resp_d;
      irq_q <= irq_d;
      int_oe_n_q <= ~irq_d;
    end
  end
  assign int_oe_n_out = int_oe_n_q;
  assign int_drive_out = 1'b0;

  // Result bytes: measurement bytes 0..5 in slots 0..2, calibration over all twelve
  wire [1:0] slot = m_q == M_VIS ? 2'h0 : m_q == M_IR ? 2'h1 : 2'h2;
  wire [15:0] meas_val = adc_sat_in ? LSP_RESULT_OVF : adc_value_in;
  for (genvar i = 0; i < LSP_RESULT_BYTES; i++) begin : g_res
    always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in || soft_rst) res_q[i] <= 8'h00;
      else if (cal_load) res_q[i] <= LSP_CAL_IMAGE[8*i +: 8];
      else if (capture && i < LSP_MEAS_BYTES && i / 2 == int'(slot)) res_q[i] <= meas_val[8*(i%2) +: 8];
    end
  end

  // Read mux for the pointer the bus side announced
  logic [7:0] rd_mux;
  wire [5:0] ridx = 6'(ptr_q - LSP_REG_RESULT0);
  always_comb begin
    if (ptr_q == LSP_REG_CHAN_LIST) rd_mux = chan_q;
    else if (ptr_q == LSP_REG_RANGE) rd_mux = range_q;
    else if (ptr_q == LSP_REG_VIS_ITIME) rd_mux = {5'h00, vis_it_q};
    else if (ptr_q == LSP_REG_IR_ITIME) rd_mux = {5'h00, ir_it_q};
    else if (ptr_q == LSP_REG_HARDWARE_UNLOCK_KEY) rd_mux = key_q;
    else if (ptr_q == LSP_REG_MEAS_RATE) rd_mux = rate_q;
    else if (ptr_q >= LSP_REG_UCOEF0 && ptr_q <= LSP_REG_UCOEF3) rd_mux = ucoef_q[2'(ptr_q - LSP_REG_UCOEF0)];
    else if (ptr_q == LSP_REG_COMMAND) rd_mux = cmd_q;
    else if (ptr_q == LSP_REG_RESPONSE) rd_mux = resp_q;
    else if (ptr_q == LSP_REG_IRQ_STATUS) rd_mux = {7'h00, irq_q};
    else if (ptr_q >= LSP_REG_RESULT0 && ptr_q <= LSP_REG_RESULT_LAST) rd_mux = res_q[ridx[3:0]];
    else rd_mux = 8'h00;
  end
  // Pointer is still for several bus clocks after its toggle, so sampling it here is safe
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) rd_data_q <= 8'h00;
    else if (rq_evt) rd_data_q <= rd_mux;
  end

  // ----------------------------------------------------------------
  // Measurement sequencer
  // ----------------------------------------------------------------
  function automatic lsp_meas_t next_meas(lsp_meas_t cur, logic ev, logic ei, logic ea);
    lsp_meas_t n;
    n = M_IDLE;
    case (cur)
      M_IDLE: if (ev) n = M_VIS; else if (ei) n = M_IR; else if (ea) n = M_AUX;
      M_VIS: if (ei) n = M_IR; else if (ea) n = M_AUX;
      M_IR: if (ea) n = M_AUX;
      default: n = M_IDLE;
    endcase
    return n;
  endfunction
  wire en_vis = chan_q[LSP_CH_VIS_BIT];
  wire en_ir = chan_q[LSP_CH_IR_BIT];
  wire en_aux = chan_q[LSP_CH_AUX_BIT] || chan_q[LSP_CH_UV_BIT];
  wire lsp_meas_t m_first = next_meas(M_IDLE, en_vis, en_ir, en_aux);
  wire lsp_meas_t m_after = next_meas(m_q, en_vis, en_ir, en_aux);
  logic [19:0] win_q, win_len;
  logic [23:0] rate_cnt_q;
  logic integ_q;
  logic [1:0] chan_sel_q;
  wire rate_tick = auto_q && rate_q != 8'h00 && rate_cnt_q == 24'h000000;
  wire go = rate_tick || (cmd_exec && wr_data_q == LSP_CMD_FORCE);
  assign capture = m_q != M_IDLE && win_q == 20'h00000;
  assign seq_done = capture && m_after == M_IDLE;
  assign ovf_set = capture && adc_sat_in;
  assign m_d = soft_rst ? M_IDLE : (m_q == M_IDLE && go) ? m_first : capture ? m_after : m_q;
  assign win_len = m_d == M_VIS ? 20'(INT_BASE_CYCLES) << vis_it_q :
                   m_d == M_IR ? 20'(INT_BASE_CYCLES) << ir_it_q : 20'(AUX_CYCLES);
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      m_q <= M_IDLE; win_q <= 20'h00000; rate_cnt_q <= 24'h000000;
      integ_q <= 1'b0; chan_sel_q <= 2'h0;
    end else begin
      m_q <= m_d;
      win_q <= (m_d != m_q) ? 20'(win_len - 20'h00001) : (win_q != 20'h00000 ? 20'(win_q - 20'h00001) : win_q);
      if (!auto_q || rate_tick) rate_cnt_q <= 24'(rate_q * RATE_TICK_CYCLES - 1);
      else rate_cnt_q <= 24'(rate_cnt_q - 24'h000001);
      integ_q <= m_d != M_IDLE;
      chan_sel_q <= m_d == M_VIS ? 2'h0 : m_d == M_IR ? 2'h1 : 2'h2;
    end
  end
  assign integrate_out = integ_q;
  assign meas_chan_out = chan_sel_q;
  assign vis_high_range_out = range_q[LSP_RANGE_VIS_BIT];
  assign ir_high_range_out = range_q[LSP_RANGE_IR_BIT];
  assign ucoef_out = {ucoef_q[3], ucoef_q[2], ucoef_q[1], ucoef_q[0]};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_last_cap;
    capture && m_after == M_IDLE;
  endsequence
  a_addr_ack: assert property (@(posedge scl_in) disable iff (!rst_n_in) lk_q == LK_AACK |-> !sda_oe_n_out)
    else $error("address not acknowledged");
  a_ptr_hold: assert property (@(posedge scl_in) disable iff (!rst_n_in)
    (lk_q == LK_RDAT && $past(lk_q) == LK_RACK && ainc_dis_q) |-> ptr_q == $past(ptr_q))
    else $error("pointer moved with increment disabled");
  a_cmd_count: assert property (@(posedge clock_in) disable iff (!rst_n_in || soft_rst)
    cmd_exec && !is_nop |=> resp_q[3:0] == 4'($past(resp_q[3:0]) + 4'h1))
    else $error("command counter did not advance");
  a_ovf_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    resp_q[LSP_RESP_OVF_BIT] && !(cmd_exec && is_nop) && !soft_rst |=> resp_q[LSP_RESP_OVF_BIT])
    else $error("overflow flag dropped early");
  a_sat_ffff: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    capture && adc_sat_in && !soft_rst && !cal_load |=> {res_q[2*$past(slot)+1], res_q[2*$past(slot)]} == LSP_RESULT_OVF
      && resp_q[LSP_RESP_OVF_BIT])
    else $error("saturation not reported");
  a_val_norm: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    capture && !adc_sat_in && !soft_rst && !cal_load
      |=> {res_q[2*$past(slot)+1], res_q[2*$past(slot)]} == $past(adc_value_in))
    else $error("result not stored");
  a_irq_set: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    s_last_cap and !soft_rst |=> !int_oe_n_out ##1 !int_oe_n_out || wr_evt || soft_rst)
    else $error("interrupt not raised after measurement");
  a_irq_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !int_oe_n_out && !wr_evt && !soft_rst |=> !int_oe_n_out)
    else $error("interrupt released without clear");
  a_ir_skip: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    m_q != M_IR ##1 m_q == M_IR |-> $past(en_ir))
    else $error("disabled infrared measurement ran");
  a_cal_load: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    cal_load |=> res_q[0] == LSP_CAL_IMAGE[7:0] && res_q[11] == LSP_CAL_IMAGE[95:88])
    else $error("calibration not loaded");
endmodule

//--- logic/lsp_pkg.sv
/*
  Constants and types for the light sensor host port: the bus address,
  register offsets, field positions, reset values, commands and timing.
  Assumes a 100 MHz system clock and a bus clock from the host.
*/
package lsp_pkg;
  // ----------------------------------------------------------------
  // Bus addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] LSP_SLAVE_ADDR = 7'h60;
  localparam logic [7:0] LSP_GC_ADDR = 8'h00;
  localparam logic [7:0] LSP_GC_RESET = 8'h06;
  localparam int LSP_PTR_AINC_BIT = 6;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] LSP_REG_CHAN_LIST = 6'h01;
  localparam logic [5:0] LSP_REG_RANGE = 6'h02;
  localparam logic [5:0] LSP_REG_VIS_ITIME = 6'h04;
  localparam logic [5:0] LSP_REG_IR_ITIME = 6'h05;
  localparam logic [5:0] LSP_REG_HARDWARE_UNLOCK_KEY = 6'h07;
  localparam logic [5:0] LSP_REG_MEAS_RATE = 6'h08;
  localparam logic [5:0] LSP_REG_UCOEF0 = 6'h13;
  localparam logic [5:0] LSP_REG_UCOEF3 = 6'h16;
  localparam logic [5:0] LSP_REG_COMMAND = 6'h18;
  localparam logic [5:0] LSP_REG_RESPONSE = 6'h20;
  localparam logic [5:0] LSP_REG_IRQ_STATUS = 6'h21;
  localparam logic [5:0] LSP_REG_RESULT0 = 6'h22;
  localparam logic [5:0] LSP_REG_RESULT_LAST = 6'h2D;
  localparam int LSP_RESULT_BYTES = 12;
  localparam int LSP_MEAS_BYTES = 6;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int LSP_CH_VIS_BIT = 4;
  localparam int LSP_CH_IR_BIT = 5;
  localparam int LSP_CH_AUX_BIT = 6;
  localparam int LSP_CH_UV_BIT = 7;
  localparam int LSP_RANGE_VIS_BIT = 0;
  localparam int LSP_RANGE_IR_BIT = 1;
  localparam int LSP_RESP_OVF_BIT = 7;
  localparam int LSP_IRQ_DONE_BIT = 0;
  localparam logic [7:0] LSP_BYTE_RST = 8'h00;
  localparam logic [2:0] LSP_ITIME_RST = 3'h0;
  localparam logic [15:0] LSP_RESULT_OVF = 16'hFFFF;
  // Calibration image, values arbitrary
  localparam logic [95:0] LSP_CAL_IMAGE = 96'h0C0B0A09_08070605_04030201;
  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  localparam logic [7:0] LSP_CMD_NOP = 8'h00;
  localparam logic [7:0] LSP_CMD_RESET = 8'h01;
  localparam logic [7:0] LSP_CMD_FORCE = 8'h06;
  localparam logic [7:0] LSP_CMD_PAUSE = 8'h0B;
  localparam logic [7:0] LSP_CMD_AUTO = 8'h0E;
  localparam logic [7:0] LSP_CMD_GET_CAL = 8'h12;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int LSP_CLK_MHZ = 100;
  localparam int LSP_INT_BASE_TENTH_US = 256;  // 25.6 us, code 7 gives 3.28 ms
  localparam int LSP_INT_BASE_CYC = LSP_INT_BASE_TENTH_US * LSP_CLK_MHZ / 10;
  localparam int LSP_AUX_TIME_US = 285;
  localparam int LSP_AUX_CYC = LSP_AUX_TIME_US * LSP_CLK_MHZ;
  localparam int LSP_RATE_TICK_US = 32;
  localparam int LSP_RATE_TICK_CYC = LSP_RATE_TICK_US * LSP_CLK_MHZ;
  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [10:0] {
    LK_IDLE = 11'h001, LK_ADDR = 11'h002, LK_AACK = 11'h004, LK_PTR = 11'h008,
    LK_PACK = 11'h010, LK_WDAT = 11'h020, LK_WACK = 11'h040, LK_RDAT = 11'h080,
    LK_RACK = 11'h100, LK_GCMD = 11'h200, LK_GACK = 11'h400
  } lsp_link_t;
  typedef enum logic [3:0] {
    M_IDLE = 4'h1, M_VIS = 4'h2, M_IR = 4'h4, M_AUX = 4'h8
  } lsp_meas_t;
endpackage

//--- verification/lsp_host_model.sv
/*
  Behavioural bus master standing in for the host controller.
  Assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/100ps
module lsp_host_model (
  // Bus pins
  output logic scl_out,
  output logic sda_out,
  input wire logic sda_in
);
  // Bus clock stands still high outside frames
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // 15 ns bit, data moves only while the clock is low
  task automatic bitx(input logic b, output logic s);
    scl_out = 1'b0;
    #3 sda_out = b;
    #4.5 scl_out = 1'b1;
    #3.5 s = sda_in;
    #4;
  endtask
  task automatic start();
    scl_out = 1'b0;
    #3 sda_out = 1'b1;
    #4 scl_out = 1'b1;
    #8 sda_out = 1'b0;
    #8;
  endtask
  task automatic stop();
    scl_out = 1'b0;
    #3 sda_out = 1'b0;
    #4 scl_out = 1'b1;
    #8 sda_out = 1'b1;
    #8;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(b[i], s);
    bitx(1'b1, s);
    ack = ~s;
  endtask
  // Released line floats to the pull-up, so a silent device reads ones
  task automatic rbyte(output logic [7:0] b, input logic last);
    logic s;
    for (int i = 0; i < 8; i++) begin
      bitx(1'b1, s);
      b = {b[6:0], s};
    end
    bitx(last, s);
  endtask
endmodule

//--- verification/test_light_sensor_i2c_host_port.sv
/*
  Self-checking bench for the host port: bus framing, pointer, commands,
  overflow and interrupt. Assumes the host model above on the bus side.
*/
`timescale 1ns/100ps
module test_light_sensor_i2c_host_port;
  import lsp_pkg::*;
  logic clock_in = 1'b0, rst_n_in = 1'b1, adc_sat_in = 1'b0, a;
  logic [15:0] adc_value_in = 16'h0000;
  logic scl, sda_host, sda_drv, sda_oe_n, int_drv, int_oe_n_out, integ, vis_hr, ir_hr;
  logic [1:0] chan;
  logic [31:0] ucoef;
  logic [7:0] rq [0:3];
  wire sda_in = sda_host & (sda_oe_n | sda_drv);
  int miscompares = 0, cmp_count = 0, cycles = 0, win_len = 0, saw_ir = 0;
  always #5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles++;
    if (integ === 1'b1) win_len++;
    if (integ === 1'b1 && chan === 2'd1) saw_ir = 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  lsp_host_model HOST (.scl_out(scl), .sda_out(sda_host), .sda_in(sda_in));
  lsp_host_port #(.INT_BASE_CYCLES(8), .AUX_CYCLES(8), .RATE_TICK_CYCLES(16)) DUT (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_in),
    .sda_drive_out(sda_drv), .sda_oe_n_out(sda_oe_n), .int_drive_out(int_drv),
    .int_oe_n_out(int_oe_n_out), .adc_value_in(adc_value_in), .adc_sat_in(adc_sat_in),
    .integrate_out(integ), .meas_chan_out(chan), .vis_high_range_out(vis_hr),
    .ir_high_range_out(ir_hr), .ucoef_out(ucoef));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [31:0] d, input int n);
    HOST.start();
    HOST.wbyte(8'hC0, a);
    HOST.wbyte(p, a);
    for (int i = 0; i < n; i++) HOST.wbyte(d[8*i+:8], a);
    HOST.stop();
  endtask
  // Pointer set by a two-byte write, then a repeated start to read
  task automatic rd(input logic [7:0] p, input int n);
    HOST.start();
    HOST.wbyte(8'hC0, a);
    HOST.wbyte(p, a);
    HOST.start();
    HOST.wbyte(8'hC1, a);
    for (int i = 0; i < n; i++) HOST.rbyte(rq[i], i == n - 1);
    HOST.stop();
  endtask
  task automatic force_meas();
    win_len = 0;
    wr(8'h18, {24'h0, LSP_CMD_FORCE}, 1);
    for (int i = 0; i < 400 && int_oe_n_out !== 1'b0; i++) @(posedge clock_in);
    check("irq pin", 1'b0, int_oe_n_out);
    check("irq drive level", 1'b0, int_drv);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_addr();
    HOST.start();
    HOST.wbyte(8'hC2, a);
    check("ack other addr", 1'b0, a);
    HOST.start();
    HOST.wbyte(8'hF0, a);
    check("ack ten-bit header", 1'b0, a);
    HOST.start();
    HOST.wbyte(8'hC0, a);
    check("ack own addr", 1'b1, a);
    HOST.wbyte(8'h07, a);
    HOST.wbyte(8'h17, a);
    HOST.stop();
  endtask
  task automatic t_burst();
    wr(8'h01, 32'h0000_0390, 2);
    check("range pins", 2'b11, {ir_hr, vis_hr});
    wr(8'h13, 32'h0001_6B7B, 4);
    check("coef pins", 32'h0001_6B7B, ucoef);
    rd(8'h13, 4);
    check("coef burst read", 32'h0001_6B7B, {rq[3], rq[2], rq[1], rq[0]});
    rd(8'h53, 2);
    check("fixed pointer", 16'h7B7B, {rq[1], rq[0]});
  endtask
  task automatic t_cal();
    wr(8'h18, {24'h0, LSP_CMD_GET_CAL}, 1);
    rd(8'h22, 1);
    check("cal first", LSP_CAL_IMAGE[7:0], rq[0]);
    rd(8'h2D, 1);
    check("cal last", LSP_CAL_IMAGE[95:88], rq[0]);
    rd(8'h20, 1);
    check("response count", 8'h01, rq[0]);
  endtask
  task automatic t_ovf();
    @(posedge clock_in);
    adc_sat_in <= 1'b1;
    adc_value_in <= 16'h1234;
    force_meas();
    check("window length", 16, win_len);
    rd(8'h20, 1);
    check("response ovf", 8'h82, rq[0]);
    rd(8'h22, 2);
    check("saturated result", LSP_RESULT_OVF, {rq[1], rq[0]});
    check("irq held", 1'b0, int_oe_n_out);
    wr(8'h21, 32'h1, 1);
    repeat (5) @(posedge clock_in);
    check("irq cleared", 1'b1, int_oe_n_out);
    adc_sat_in <= 1'b0;
    force_meas();
    rd(8'h22, 2);
    check("recovered result", 16'h1234, {rq[1], rq[0]});
    rd(8'h26, 2);
    check("aux result", 16'h1234, {rq[1], rq[0]});
    rd(8'h20, 1);
    check("ovf kept", 8'h83, rq[0]);
    check("infrared skipped", 0, saw_ir);
    wr(8'h18, {24'h0, LSP_CMD_NOP}, 1);
    rd(8'h20, 1);
    check("nop clears", 8'h00, rq[0]);
  endtask
  task automatic t_gcall();
    HOST.start();
    HOST.wbyte(LSP_GC_ADDR, a);
    check("ack general call", 1'b1, a);
    HOST.wbyte(LSP_GC_RESET, a);
    HOST.stop();
    repeat (10) @(posedge clock_in);
    check("coef after reset", 32'h0, ucoef);
    check("irq after reset", 1'b1, int_oe_n_out);
  endtask
  // Infrared enabled with its own integration code
  task automatic t_ir();
    wr(8'h21, 32'h1, 1);
    wr(8'h04, 32'h0000_0100, 2);
    wr(8'h01, 32'h0000_00B0, 1);
    force_meas();
    check("ir window", 1, saw_ir);
    check("three windows", 32, win_len);
  endtask
  // Autonomous run by the rate counter, then pause and the reset command
  task automatic t_auto();
    wr(8'h01, 32'h0000_0010, 1);
    wr(8'h08, 32'h0000_0001, 1);
    wr(8'h18, {24'h0, LSP_CMD_AUTO}, 1);
    for (int i = 0; i < 400 && int_oe_n_out !== 1'b0; i++) @(posedge clock_in);
    check("auto irq", 1'b0, int_oe_n_out);
    wr(8'h18, {24'h0, LSP_CMD_PAUSE}, 1);
    wr(8'h21, 32'h1, 1);
    win_len = 0;
    repeat (100) @(posedge clock_in);
    check("paused windows", 0, win_len);
    check("irq after pause", 1'b1, int_oe_n_out);
    wr(8'h18, {24'h0, LSP_CMD_RESET}, 1);
    rd(8'h01, 1);
    check("chan after reset cmd", 8'h00, rq[0]);
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    t_gcall();
    t_addr();
    t_burst();
    t_cal();
    t_ovf();
    t_ir();
    t_gcall();
    t_auto();
    tally_and_finish();
  end
endmodule
